/* File: hdl/dat_adpcm_transcoder.sv */
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dat_adpcm_transcoder
  import dat_pkg::*;
#(
  parameter int FRAME_BITS = 512
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_port_mode_strap,
  input wire logic [5:0] i_device_address,
  input wire logic i_control_serial_clock,
  input wire logic i_control_serial_input,
  input wire logic i_control_select_n,
  input wire logic i_x_side_bit_clock,
  input wire logic i_x_side_frame_sync,
  input wire logic i_x_side_serial_in,
  output logic o_x_side_serial_out,
  output logic o_x_side_serial_out_en,
  input wire logic i_y_side_bit_clock,
  input wire logic i_y_side_frame_sync,
  input wire logic i_y_side_serial_in,
  output logic o_y_side_serial_out,
  output logic o_y_side_serial_out_en,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);
  logic [PIN_W-1:0] s1_r, s2_r, s3_r, f_r, f_nxt, async_in;
  logic [DAT_CH-1:0] up_req, dn_ack, bclk, y_side_frame_sync, sin, sout, soe;
  logic sck_prev_r, csn_prev_r, strap_prev_r;
  logic [SER_LEN-1:0] ssh_r, ssh_nxt;
  logic [4:0] sbit_r, sbit_nxt;
  logic [CTRL_W-1:0] ctrl_r [DAT_CH];
  logic [CTRL_W-1:0] ctrl_nxt [DAT_CH];
  logic [CTRL_W-1:0] eff_ctrl [DAT_CH];
  logic [TS_W-1:0] its_r [DAT_CH];
  logic [TS_W-1:0] its_nxt [DAT_CH];
  logic [TS_W-1:0] ots_r [DAT_CH];
  logic [TS_W-1:0] ots_nxt [DAT_CH];
  logic [TS_W-1:0] eff_its [DAT_CH];
  logic [TS_W-1:0] eff_ots [DAT_CH];
  logic sw_mode;
  logic [31:0] cfg_r, cfg_nxt, rdata_nxt;
  logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
  logic [ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic bv_r, bv_nxt, arrdy_r, arrdy_nxt, rv_r, rv_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r;
  logic do_wr;

  //////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a bit changes when stages 2 and 3 agree
  assign async_in = {dn_ack, up_req, i_port_mode_strap, i_device_address,
                     i_control_serial_clock, i_control_serial_input,
                     i_control_select_n};
  assign f_nxt = (s2_r & s3_r) | (f_r & (s2_r | s3_r));

  always_ff @(posedge i_clk) begin
    s1_r <= async_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (!i_resetn) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign sw_mode = f_r[PIN_STRAP];

  //////////////////////////////////////////////////////////////////
  // Serial control port and channel settings
  always_comb begin
    ssh_nxt = ssh_r;
    sbit_nxt = sbit_r;
    do_wr = 1'b0;
    ctrl_nxt = ctrl_r;
    its_nxt = its_r;
    ots_nxt = ots_r;
    if (f_r[PIN_CSN]) begin
      sbit_nxt = '0;
    end else if (f_r[PIN_SCK] && !sck_prev_r) begin
      ssh_nxt = {ssh_r[SER_LEN-2:0], f_r[PIN_SDI]};
      sbit_nxt = (sbit_r == 5'h1F) ? sbit_r : sbit_r + 1'b1;
    end
    // Commit on select release; hardware mode ignores the port
    if (f_r[PIN_CSN] && !csn_prev_r && sbit_r == 5'(SER_LEN) &&
        sw_mode &&
        ssh_r[SER_LEN-1:SER_ADDR_LSB] ==
        f_r[PIN_ADDR +: 6]) begin
      do_wr = 1'b1;
    end
    for (int c = 0; c < DAT_CH; c++) begin
      if (do_wr) begin
        if (ssh_r[SER_SEL_LSB +: 3] == SEL_CTRL0 + 3'(c)) begin
          ctrl_nxt[c] = ssh_r[CTRL_W-1:0];
        end
        if (ssh_r[SER_SEL_LSB +: 3] == SEL_ITS0 + 3'(2 * c)) begin
          its_nxt[c] = ssh_r[TS_W-1:0];
        end
        if (ssh_r[SER_SEL_LSB +: 3] == SEL_OTS0 + 3'(2 * c)) begin
          ots_nxt[c] = ssh_r[TS_W-1:0];
        end
      end
      // A mode change clears all settings as a reset would
      if (sw_mode != strap_prev_r) begin
        ctrl_nxt[c] = CTRL_RST;
        its_nxt[c] = '0;
        ots_nxt[c] = '0;
      end
    end
  end

  // Reset loads the idle setting into both channel control registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ssh_r <= '0;
      sbit_r <= '0;
      sck_prev_r <= 1'b0;
      csn_prev_r <= 1'b1;
      strap_prev_r <= 1'b0;
      for (int c = 0; c < DAT_CH; c++) begin
        ctrl_r[c] <= CTRL_RST;
        its_r[c] <= '0;
        ots_r[c] <= '0;
      end
    end else begin
      ssh_r <= ssh_nxt;
      sbit_r <= sbit_nxt;
      sck_prev_r <= f_r[PIN_SCK];
      csn_prev_r <= f_r[PIN_CSN];
      strap_prev_r <= sw_mode;
      ctrl_r <= ctrl_nxt;
      its_r <= its_nxt;
      ots_r <= ots_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Per channel: link, crossing and engine, independent
  assign bclk = {i_y_side_bit_clock, i_x_side_bit_clock};
  assign y_side_frame_sync = {i_y_side_frame_sync, i_x_side_frame_sync};
  assign sin = {i_y_side_serial_in, i_x_side_serial_in};

  for (genvar g = 0; g < DAT_CH; g++) begin : g_ch
    localparam int HB = PIN_ADDR + HW_STRIDE * g;
    dat_xfer_if xf ();
    logic seen_r, seen_nxt, dq_r, dq_nxt, hit;
    logic [7:0] wd, word_r, word_nxt, pcm, v;
    logic half_r, half_nxt;
    logic signed [9:0] pred_r, pred_nxt, s, d, ad, r, p, ap;
    logic [2:0] mag;
    logic [3:0] code;
    dat_dn_t dn_r, dn_nxt, asm_b;

    dat_tdm_link #(.FRAME_BITS(FRAME_BITS)) u_link (
      .i_bit_clk(bclk[g]),
      .i_resetn(i_resetn),
      .i_frame_sync(y_side_frame_sync[g]),
      .i_serial_in(sin[g]),
      .o_serial_out(sout[g]),
      .o_serial_oe(soe[g]),
      .xf(xf.link)
    );

    assign up_req[g] = xf.up_req;
    assign dn_ack[g] = xf.dn_ack;
    // Word is held stable in the link until its next slot
    assign wd = xf.up_word;

    // Hardware mode: settings from pins, slots fixed at zero
    always_comb begin
      eff_ctrl[g] = ctrl_r[g];
      eff_its[g] = its_r[g];
      eff_ots[g] = ots_r[g];
      if (!sw_mode) begin
        eff_ctrl[g] = '0;
        eff_ctrl[g][CB_CMP] = f_r[HB + HW_CMP];
        eff_ctrl[g][CB_IDLE] = f_r[HB + HW_IDLE];
        eff_ctrl[g][CB_MU] = f_r[HB + HW_MU];
        eff_its[g] = '0;
        eff_ots[g] = '0;
      end
    end

    // Simplified adaptive coder: 8-bit PCM to 4-bit code
    always_comb begin
      v = wd ^ (eff_ctrl[g][CB_MU] ? MULAW_XOR : ALAW_XOR);
      s = v[7] ? -$signed({3'h0, v[6:0]}) : $signed({3'h0, v[6:0]});
      d = s - pred_r;
      ad = d[9] ? -d : d;
      mag = (ad[9:4] > 6'(MAG_MAX)) ? MAG_MAX : ad[6:4];
      code = eff_ctrl[g][CB_CMP] ? {d[9], mag} : wd[7:4];
      r = $signed({3'h0, code[2:0], RECON_HALF});
      p = code[3] ? pred_r - r : pred_r + r;
      if (p > PRED_MAX) begin
        p = PRED_MAX;
      end else if (p < -PRED_MAX) begin
        p = -PRED_MAX;
      end
      ap = p[9] ? -p : p;
      pcm = {p[9], ap[6:0]} ^
            (eff_ctrl[g][CB_MU] ? MULAW_XOR : ALAW_XOR);
      hit = f_r[PIN_UP + g] != seen_r;
      seen_nxt = f_r[PIN_UP + g];
      pred_nxt = pred_r;
      word_nxt = word_r;
      half_nxt = half_r;
      if (eff_ctrl[g][CB_RST] || eff_ctrl[g][CB_IDLE]) begin
        pred_nxt = '0; // Algorithm held in reset
      end else if (hit && cfg_r[0]) begin
        if (eff_ctrl[g][CB_BYP]) begin
          word_nxt = wd;
          half_nxt = 1'b0;
        end else if (eff_ctrl[g][CB_CMP]) begin
          word_nxt = {code, 4'h0};
          half_nxt = 1'b1;
          pred_nxt = p;
        end else begin
          word_nxt = pcm;
          half_nxt = 1'b0;
          pred_nxt = p;
        end
      end
      asm_b = '{act: !eff_ctrl[g][CB_IDLE], half: half_nxt,
                its: eff_its[g], ots: eff_ots[g], word: word_nxt};
      dn_nxt = dn_r;
      dq_nxt = dq_r;
      // New bundle only after the previous one was acknowledged
      if (f_r[PIN_ACK + g] == dq_r && asm_b != dn_r) begin
        dn_nxt = asm_b;
        dq_nxt = ~dq_r;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        seen_r <= 1'b0;
        pred_r <= '0;
        word_r <= '0;
        half_r <= 1'b0;
        dn_r <= '0;
        dq_r <= 1'b0;
      end else begin
        seen_r <= seen_nxt;
        pred_r <= pred_nxt;
        word_r <= word_nxt;
        half_r <= half_nxt;
        dn_r <= dn_nxt;
        dq_r <= dq_nxt;
      end
    end

    assign xf.dn = dn_r;
    assign xf.dn_req = dq_r;
  end

  assign o_x_side_serial_out = sout[0];
  assign o_x_side_serial_out_en = soe[0];
  assign o_y_side_serial_out = sout[1];
  assign o_y_side_serial_out_en = soe[1];

  //////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; one write and one read in flight
  always_comb begin
    aw_h_nxt = aw_h_r | (i_s_axi_awvalid & awrdy_r);
    w_h_nxt = w_h_r | (i_s_axi_wvalid & wrdy_r);
    awa_nxt = (i_s_axi_awvalid & awrdy_r) ? i_s_axi_awaddr : awa_r;
    wd_nxt = (i_s_axi_wvalid & wrdy_r) ? i_s_axi_wdata : wd_r;
    ws_nxt = (i_s_axi_wvalid & wrdy_r) ? i_s_axi_wstrb : ws_r;
    bv_nxt = bv_r & ~i_s_axi_bready;
    bresp_nxt = bresp_r;
    cfg_nxt = cfg_r;
    if (aw_h_r && w_h_r && !bv_r) begin
      aw_h_nxt = 1'b0;
      w_h_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = (awa_r == REG_CFG || awa_r == REG_STAT ||
                   awa_r == REG_CTRL0 || awa_r == REG_CTRL0 + 8'h4 ||
                   awa_r == REG_TS0 || awa_r == REG_TS0 + 8'h4) ?
                  RESP_OKAY : RESP_SLVERR;
      if (awa_r == REG_CFG && ws_r[0]) begin
        cfg_nxt = {31'h0, wd_r[0]}; // Engine enable
      end
    end
    awrdy_nxt = ~aw_h_nxt & ~bv_nxt;
    wrdy_nxt = ~w_h_nxt & ~bv_nxt;
    rv_nxt = rv_r & ~i_s_axi_rready;
    arrdy_nxt = ~rv_nxt;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (i_s_axi_arvalid && arrdy_r) begin
      rv_nxt = 1'b1;
      arrdy_nxt = 1'b0;
      rresp_nxt = RESP_OKAY;
      case (i_s_axi_araddr)
        REG_CFG: rdata_nxt = cfg_r;
        REG_STAT: rdata_nxt = {25'h0, sw_mode, f_r[PIN_ADDR +: 6]};
        REG_CTRL0: rdata_nxt = {27'h0, eff_ctrl[0]};
        REG_CTRL0 + 8'h4: rdata_nxt = {27'h0, eff_ctrl[1]};
        REG_TS0: rdata_nxt = {18'h0, eff_ots[0], 2'h0, eff_its[0]};
        REG_TS0 + 8'h4: rdata_nxt = {18'h0, eff_ots[1], 2'h0,
                                     eff_its[1]};
        default: begin
          rdata_nxt = '0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      bv_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arrdy_r <= 1'b0;
      rv_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
      cfg_r <= CFG_RST;
    end else begin
      aw_h_r <= aw_h_nxt;
      w_h_r <= w_h_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      awrdy_r <= awrdy_nxt;
      wrdy_r <= wrdy_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      arrdy_r <= arrdy_nxt;
      rv_r <= rv_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign o_s_axi_awready = awrdy_r;
  assign o_s_axi_wready = wrdy_r;
  assign o_s_axi_bvalid = bv_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = arrdy_r;
  assign o_s_axi_rvalid = rv_r;
  assign o_s_axi_rresp = rresp_r;
  assign o_s_axi_rdata = rdata_r;
endmodule

/* File: hdl/dat_pkg.sv */
package dat_pkg;
  // Channel and frame geometry
  localparam int DAT_CH = 2;
  localparam int TS_W = 6;
  localparam int CNT_W = 9;
  localparam int FRAME_BITS_MAX = 512;
  localparam int HALF_BITS = 4;
  // Serial command word: addr[15:10] sel[9:7] data[5:0]
  localparam int SER_LEN = 16;
  localparam int SER_ADDR_LSB = 10;
  localparam int SER_SEL_LSB = 7;
  localparam logic [2:0] SEL_CTRL0 = 3'h0;
  localparam logic [2:0] SEL_ITS0 = 3'h2;
  localparam logic [2:0] SEL_OTS0 = 3'h3;
  // Channel control bits
  localparam int CTRL_W = 5;
  localparam int CB_RST = 0;
  localparam int CB_MU = 1;
  localparam int CB_CMP = 2;
  localparam int CB_BYP = 3;
  localparam int CB_IDLE = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h10;
  // Strap mapping in hardware mode, three pins per channel
  localparam int HW_CMP = 0;
  localparam int HW_IDLE = 1;
  localparam int HW_MU = 2;
  localparam int HW_STRIDE = 3;
  // Synchronised pin vector positions
  localparam int PIN_CSN = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_ADDR = 3;
  localparam int PIN_STRAP = 9;
  localparam int PIN_UP = 10;
  localparam int PIN_ACK = 12;
  localparam int PIN_W = 14;
  // Companding
  localparam logic [7:0] ALAW_XOR = 8'h55;
  localparam logic [7:0] MULAW_XOR = 8'hFF;
  localparam logic signed [9:0] PRED_MAX = 10'sh07F;
  localparam logic [2:0] MAG_MAX = 3'h7;
  localparam logic [3:0] RECON_HALF = 4'h8;
  // AXI4-Lite map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CTRL0 = 8'h08;
  localparam logic [7:0] REG_TS0 = 8'h10;
  localparam logic [31:0] CFG_RST = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic act;
    logic half;
    logic [TS_W-1:0] its;
    logic [TS_W-1:0] ots;
    logic [7:0] word;
  } dat_dn_t;
endpackage

/* File: hdl/dat_xfer_if.sv */
`timescale 1ns/1ps
interface dat_xfer_if;
  import dat_pkg::*;
  dat_dn_t dn;
  logic dn_req;
  logic dn_ack;
  logic [7:0] up_word;
  logic up_req;
  modport core(output dn, output dn_req, input dn_ack,
               input up_word, input up_req);
  modport link(input dn, input dn_req, output dn_ack,
               output up_word, output up_req);
endinterface

/* File: hdl/dat_tdm_link.sv */
`timescale 1ns/1ps
module dat_tdm_link
  import dat_pkg::*;
#(
  parameter int FRAME_BITS = 512
) (
  input wire logic i_bit_clk,
  input wire logic i_resetn,
  input wire logic i_frame_sync,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_serial_oe,
  dat_xfer_if.link xf
);
  if (FRAME_BITS < 8 || FRAME_BITS > FRAME_BITS_MAX ||
      FRAME_BITS % 8 != 0) begin : g_chk
    $error("FRAME_BITS out of range");
  end

  logic rst_s1_r, rst_s2_r, rst_s3_r, run;
  logic q1_r, q2_r, q3_r, ack_r, ack_nxt;
  dat_dn_t cfg_r, cfg_nxt;
  logic fs_prev_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, pos_r, cur;
  logic out_r, out_nxt, oe_r, oe_nxt;
  logic [7:0] sh_r, sh_nxt, upw_r, upw_nxt;
  logic upq_r, upq_nxt;

  //////////////////////////////////////////////////////////////////
  // Reset and settings handshake into the bit clock domain
  always_ff @(posedge i_bit_clk) begin
    rst_s1_r <= i_resetn;
    rst_s2_r <= rst_s1_r;
    rst_s3_r <= rst_s2_r;
    q1_r <= xf.dn_req;
    q2_r <= q1_r;
    q3_r <= q2_r;
  end

  // Link runs only once stages 2 and 3 both see reset released
  assign run = rst_s2_r & rst_s3_r;

  // Settings latched only once the request toggle is stable
  always_comb begin
    ack_nxt = ack_r;
    cfg_nxt = cfg_r;
    if (q2_r == q3_r && q2_r != ack_r) begin
      ack_nxt = q2_r;
      cfg_nxt = xf.dn;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Bit counter and output slot, rising edge
  always_comb begin
    // Frame start restarts the count at bit 0
    cur = (i_frame_sync && !fs_prev_r) ? '0 : cnt_r;
    cnt_nxt = (cur == CNT_W'(FRAME_BITS - 1)) ? '0 : cur + 1'b1;
    // Drive only inside the output slot; half slot for codes
    oe_nxt = cfg_r.act && cur[CNT_W-1:3] == cfg_r.ots &&
             (!cfg_r.half || cur[2:0] < 3'(HALF_BITS));
    out_nxt = oe_nxt ? cfg_r.word[3'h7 - cur[2:0]] : 1'b0;
  end

  // Output updated on the rising edge
  always_ff @(posedge i_bit_clk) begin
    if (!run) begin
      ack_r <= 1'b0;
      cfg_r <= '0;
      fs_prev_r <= 1'b0;
      cnt_r <= '0;
      pos_r <= '0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      cfg_r <= cfg_nxt;
      fs_prev_r <= i_frame_sync;
      cnt_r <= cnt_nxt;
      pos_r <= cur;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Input slot capture, falling edge
  always_comb begin
    sh_nxt = sh_r;
    upw_nxt = upw_r;
    upq_nxt = upq_r;
    if (cfg_r.act && pos_r[CNT_W-1:3] == cfg_r.its) begin
      sh_nxt = {sh_r[6:0], i_serial_in};
      if (pos_r[2:0] == 3'h7) begin
        upw_nxt = sh_nxt;
        upq_nxt = ~upq_r; // Word held until next slot
      end
    end
  end

  // Input sampled on the falling edge
  always_ff @(negedge i_bit_clk) begin
    if (!run) begin
      sh_r <= '0;
      upw_r <= '0;
      upq_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      upw_r <= upw_nxt;
      upq_r <= upq_nxt;
    end
  end

  assign xf.dn_ack = ack_r;
  assign xf.up_word = upw_r;
  assign xf.up_req = upq_r;
  assign o_serial_out = out_r;
  assign o_serial_oe = oe_r;
endmodule

/* File: bench/dat_sva.sv */
`timescale 1ns/1ps
module dat_chk (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Write taken on one edge, busy for one, answered on the next
  sequence s_wr_take;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_wr_ans;
    !o_s_axi_bvalid && !o_s_axi_awready ##1 o_s_axi_bvalid;
  endsequence
  chk_wr_answer: assert property (s_wr_take |=> s_wr_ans)
    else $error("write answer late");
  chk_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid && !o_s_axi_arready) else $error("read answer late");
  chk_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bresp lost");
  chk_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata lost");
  // Busy slave refuses new work until its answer is gone
  chk_wr_refused: assert property (o_s_axi_bvalid
    |-> !o_s_axi_awready && !o_s_axi_wready) else $error("ready while busy");
  chk_b_release: assert property (o_s_axi_bvalid && i_s_axi_bready
    |=> !o_s_axi_bvalid && o_s_axi_awready) else $error("bvalid stuck");
  chk_r_release: assert property (o_s_axi_rvalid && i_s_axi_rready
    |=> !o_s_axi_rvalid && o_s_axi_arready) else $error("rvalid stuck");
  // Checked through reset itself, so the default disable is overridden
  chk_reset_quiet: assert property (disable iff (1'b0) !i_resetn
    |=> !o_s_axi_bvalid && !o_s_axi_rvalid && !o_s_axi_arready)
    else $error("bus active in reset");
endmodule
////////////////////////////////
bind dat_adpcm_transcoder dat_chk dat_chk_inst (
  .i_clk, .i_resetn, .i_s_axi_awvalid, .o_s_axi_awready,
  .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
  .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready
);

/* File: bench/dat_pcm_model.sv */
`timescale 1ns/1ps
module dat_pcm_model #(
  parameter int FB = 64,
  parameter int PH = 7
) (
  output logic o_clk,
  output logic o_fs,
  output logic o_sin,
  input wire logic i_sout,
  input wire logic i_oe,
  input wire logic [7:0] i_byte,
  input wire logic [5:0] i_slot,
  output logic [7:0] o_word,
  output logic [3:0] o_nbits
);
  int cnt = 0;
  int nk;
  logic [7:0] sh = 8'h00;
  logic [3:0] nb = 4'h0;
  // Backplane clock runs free at 64 ns, phase unrelated to the engine
  initial begin
    o_clk = 1'b0;
    o_fs = 1'b0;
    o_sin = 1'b0;
    o_word = 8'h00;
    o_nbits = 4'h0;
    #PH;
    forever #32 o_clk = ~o_clk;
  end
  assign nk = (cnt == FB - 1) ? 0 : cnt + 1;
  // Launch after the rise; sync stands over the edge of bit 0
  always @(posedge o_clk) begin
    cnt <= nk;
    o_fs <= (nk == FB - 1);
    // Outside the slot the line toggles so stale data never passes
    o_sin <= (nk / 8 == i_slot) ? i_byte[7 - nk % 8] : ~o_sin;
  end
  // Driven bits gathered on the fall, totals kept per frame
  always @(negedge o_clk) begin
    if (cnt == 0) begin
      o_word <= sh;
      o_nbits <= nb;
    end
    nb <= (cnt == 0 ? 4'h0 : nb) + {3'h0, i_oe};
    if (i_oe) begin
      sh <= {sh[6:0], i_sout};
    end
  end
endmodule

/* File: bench/dat_adpcm_transcoder_tb_top.sv */
`timescale 1ns/1ps
module dat_adpcm_transcoder_tb_top;
  import dat_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strap = 1'b1;
  logic [5:0] dev = 6'h15;
  logic sck = 1'b0;
  logic control_serial_input = 1'b0;
  logic csn = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic xck, xfs, xsi, xso, xoe, yck, yfs, ysi, yso, yoe;
  logic [7:0] xb = 8'h00;
  logic [7:0] yb = 8'h00;
  logic [5:0] xs = 6'h00;
  logic [5:0] ys = 6'h00;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] xw, yw;
  logic [3:0] xn, yn;
  int error_cnt = 0;
  int num_checks = 0;
  // Engine clock at 50 MHz
  always #10 clk = ~clk;
  // Device, with a short frame to keep the run brief
  dat_adpcm_transcoder #(.FRAME_BITS(64)) dat_adpcm_transcoder_inst (
    .i_clk(clk), .i_resetn(rstn), .i_port_mode_strap(strap),
    .i_device_address(dev), .i_control_serial_clock(sck),
    .i_control_serial_input(control_serial_input), .i_control_select_n(csn),
    .i_x_side_bit_clock(xck), .i_x_side_frame_sync(xfs),
    .i_x_side_serial_in(xsi), .o_x_side_serial_out(xso),
    .o_x_side_serial_out_en(xoe), .i_y_side_bit_clock(yck),
    .i_y_side_frame_sync(yfs), .i_y_side_serial_in(ysi),
    .o_y_side_serial_out(yso), .o_y_side_serial_out_en(yoe),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
  // Far-side backplanes, one per PCM side
  dat_pcm_model #(.FB(64), .PH(7)) x_model (.o_clk(xck), .o_fs(xfs),
    .o_sin(xsi), .i_sout(xso), .i_oe(xoe), .i_byte(xb), .i_slot(xs),
    .o_word(xw), .o_nbits(xn));
  dat_pcm_model #(.FB(64), .PH(23)) y_model (.o_clk(yck), .o_fs(yfs),
    .o_sin(ysi), .i_sout(yso), .i_oe(yoe), .i_byte(yb), .i_slot(ys),
    .o_word(yw), .o_nbits(yn));
////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %08h exp %08h", $time, g, e);
    end
  endtask
  // Bus cycles: payload held until its own ready, answer bounded
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    if (!bvalid) error_cnt++;
    if (!bvalid) complete_run();
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    if (!rvalid) error_cnt++;
    if (!rvalid) complete_run();
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // Serial word: phases of 6 clocks, above the 4-clock minimum
  task automatic ser_wr(input logic [5:0] ad, input logic [2:0] s,
                        input logic [5:0] d);
    logic [15:0] w;
    w = {ad, s, 1'b0, d};
    @(posedge clk);
    csn <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (6) @(posedge clk);
      control_serial_input <= w[i];
      repeat (6) @(posedge clk);
      sck <= 1'b1;
      repeat (6) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (6) @(posedge clk);
    csn <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  // Defaults after reset, bus refusals, both channels silent
  task automatic t_reset;
    rd_chk(REG_STAT, 32'h55, RESP_OKAY);
    rd_chk(REG_CTRL0, {27'h0, CTRL_RST}, RESP_OKAY);
    rd_chk(REG_CTRL0 + 8'h04, {27'h0, CTRL_RST}, RESP_OKAY);
    rd_chk(8'h40, 32'h0, RESP_SLVERR);
    wr_chk(8'h40, 32'h1, RESP_SLVERR);
    wr_chk(REG_CTRL0, 32'h0, RESP_OKAY);
    rd_chk(REG_CTRL0, {27'h0, CTRL_RST}, RESP_OKAY);
    wr_chk(REG_CFG, 32'h0, RESP_OKAY);
    rd_chk(REG_CFG, 32'h0, RESP_OKAY);
    wr_chk(REG_CFG, CFG_RST, RESP_OKAY);
    // Byte lane 0 off: the enable bit must not move
    wstrb <= 4'hE;
    wr_chk(REG_CFG, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(REG_CFG, CFG_RST, RESP_OKAY);
    repeat (1100) @(posedge clk);
    chk({28'h0, xn}, 32'h0);
    chk({28'h0, yn}, 32'h0);
  endtask
  // Serial set-up: X bypass in slot 1 out 2, Y compress in 4 out 3
  task automatic t_soft;
    ser_wr(6'h16, SEL_CTRL0, 6'h0A);
    rd_chk(REG_CTRL0, {27'h0, CTRL_RST}, RESP_OKAY);
    ser_wr(6'h15, SEL_CTRL0, 6'h0A);
    ser_wr(6'h15, SEL_ITS0, 6'h01);
    ser_wr(6'h15, SEL_OTS0, 6'h02);
    ser_wr(6'h15, 3'h1, 6'h06);
    ser_wr(6'h15, 3'h5, 6'h03);
    ser_wr(6'h15, 3'h4, 6'h04);
    rd_chk(REG_CTRL0, 32'h0A, RESP_OKAY);
    rd_chk(REG_CTRL0 + 8'h04, 32'h06, RESP_OKAY);
    rd_chk(REG_TS0, 32'h0201, RESP_OKAY);
    rd_chk(REG_TS0 + 8'h04, 32'h0304, RESP_OKAY);
    xb <= 8'hA5;
    xs <= 6'h01;
    yb <= 8'h3C;
    ys <= 6'h04;
    repeat (1100) @(posedge clk);
    chk({24'h0, xw}, 32'hA5);
    chk({28'h0, xn}, 32'h8);
    chk({28'h0, yn}, 32'h4);
  endtask
  // Strapped set-up: X compress mu-law, Y expand, slots fixed at 0
  task automatic t_hw;
    strap <= 1'b0;
    dev <= 6'h05;
    xs <= 6'h00;
    ys <= 6'h00;
    repeat (20) @(posedge clk);
    ser_wr(6'h05, SEL_CTRL0, 6'h10);
    rd_chk(REG_STAT, 32'h05, RESP_OKAY);
    rd_chk(REG_CTRL0, 32'h06, RESP_OKAY);
    rd_chk(REG_CTRL0 + 8'h04, 32'h0, RESP_OKAY);
    rd_chk(REG_TS0, 32'h0, RESP_OKAY);
    repeat (1100) @(posedge clk);
    chk({28'h0, xn}, 32'h4);
    chk({28'h0, yn}, 32'h8);
  endtask
  // Reset for five engine clocks; links resynchronise it themselves
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_soft();
    t_hw();
    complete_run();
  end
endmodule
